/* common/udt_pkg.sv */
// shared types of the up/down capture/reload timer
package udt_pkg;
  typedef logic [7:0] udt_byte_t;
  typedef logic [15:0] udt_word_t;
  typedef logic [1:0] udt_clksel_t;
  typedef logic [2:0] udt_regidx_t;
endpackage

/* common/udt_regs.svh */
// register offsets, field positions, reset values and divider counts of the timer block
`ifndef UDT_REGS_SVH
`define UDT_REGS_SVH

// per-instance window: instance index in paddr[6:5], register index in paddr[4:2]
`define UDT_INST_COUNT 3
`define UDT_REG_CTRL 3'h0
`define UDT_REG_CFG 3'h1
`define UDT_REG_CNT_LO 3'h2
`define UDT_REG_CNT_HI 3'h3
`define UDT_REG_RCAP_LO 3'h4
`define UDT_REG_RCAP_HI 3'h5

// timer_control_reg fields
`define UDT_CTRL_TF 7
`define UDT_CTRL_EXF 6
`define UDT_CTRL_EXEN 3
`define UDT_CTRL_RUN 2
`define UDT_CTRL_CSEL 1
`define UDT_CTRL_CPRL 0

// timer_config_reg fields
`define UDT_CFG_IE 5
`define UDT_CFG_CLK_HI 4
`define UDT_CFG_CLK_LO 3
`define UDT_CFG_DCEN 0

// clock select codes
`define UDT_CLK_DIV12 2'h0
`define UDT_CLK_SYS 2'h1
`define UDT_CLK_EXT8 2'h2
`define UDT_CLK_DIV2 2'h3

// reset values
`define UDT_RST_BYTE 8'h00
`define UDT_RST_WORD 16'h0000

// divider terminal counts
`define UDT_DIV12_LAST 4'hb
`define UDT_EXT8_LAST 3'h7
`define UDT_WORD_MAX 16'hffff

`endif

/* src/udt_timer.sv */
// three 16-bit up/down capture/auto-reload timers behind an apb slave
//
// What this block does
// (RULE1) sixteen-bit count from two software-accessible bytes
// (RULE2) clock choice: system_clock, /2, /12, ext/8
// (RULE3) counter select picks clock or pin falls
// (RULE4) decrement enable: trigger pin sets direction
// (RULE5) with decrement enable trigger only steers direction
// (RULE6) trigger fall captures count in capture mode
// (RULE7) capture sets external flag, may interrupt
// (RULE8) capture mode up wrap sets overflow flag
// (RULE9) capture mode down wrap sets overflow flag
// (RULE10) capture needs select, run; exen gates trigger
// (RULE11) reload mode overflow flags and reloads count
// (RULE12) reload mode trigger fall also reloads count
// (RULE13) down count matching reload value loads ffff
// (RULE14) reload mode when select clear; run starts
// (RULE15) reload mode external flag toggles per wrap
// (RULE16) wrap events feed converter trigger outputs
// (RULE17) wrap events offered as uart baud ticks
// (RULE18) clock select code mapping 00..11
// (RULE19) overflow flag cleared only by software writes; external flag also by reload-mode wraps
// (RULE20) trigger reload sets the external flag
// (RULE21) pins synchronised, falls detected from samples
`timescale 1ns/10ps
`include "udt_regs.svh"

module udt_timer
  import udt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] count_input_pin,
  input wire logic [2:0] trigger_pin,
  input wire logic osc_clk_in,
  output logic [2:0] timer_irq,
  output logic [1:0] adc_start_trig,
  output logic [2:0] dac_update_trig,
  output logic [2:0] uart0_baud_tick
);

  // bus decode
  logic access;
  logic apb_wr;
  logic addr_ok;
  logic [1:0] inst_sel;
  udt_regidx_t reg_sel;
  udt_byte_t wbyte;
  udt_byte_t rd_byte;
  logic [2:0][7:0] rd_ctrl;
  logic [2:0][7:0] rd_cfg;
  logic [2:0][7:0] rd_cnt_lo;
  logic [2:0][7:0] rd_cnt_hi;
  logic [2:0][7:0] rd_rcap_lo;
  logic [2:0][7:0] rd_rcap_hi;
  logic [2:0] ev_all;
  logic [2:0] irq_all;

  // shared prescalers
  logic [3:0] div12_cnt;
  logic div2_q;
  logic tick12;
  logic tick2;
  logic osc_s1;
  logic osc_s2;
  logic osc_prev;
  logic [2:0] ext_cnt;
  logic osc_rise;
  logic tick8;

  // one wait state: pready rises in the second access cycle
  assign access = psel & penable & ~pready;
  assign apb_wr = psel & penable & pready & pwrite;
  assign inst_sel = paddr[6:5];
  assign reg_sel = paddr[4:2];
  assign wbyte = pwdata[7:0];

  // address check; gaps and unused instance slot answer with an error
  always_comb begin
    addr_ok = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      addr_ok = 1'b0;
    end else if (paddr[7] != 1'b0) begin
      addr_ok = 1'b0;
    end else if (inst_sel == 2'h3) begin
      addr_ok = 1'b0;
    end else if (reg_sel > `UDT_REG_RCAP_HI) begin
      addr_ok = 1'b0;
    end else begin
      addr_ok = 1'b1;
    end
  end

  // read mux over the selected instance
  always_comb begin
    rd_byte = 8'h00;
    if (!addr_ok) begin
      rd_byte = 8'h00;
    end else if (reg_sel == `UDT_REG_CTRL) begin
      rd_byte = rd_ctrl[inst_sel];
    end else if (reg_sel == `UDT_REG_CFG) begin
      rd_byte = rd_cfg[inst_sel];
    end else if (reg_sel == `UDT_REG_CNT_LO) begin
      rd_byte = rd_cnt_lo[inst_sel];
    end else if (reg_sel == `UDT_REG_CNT_HI) begin
      rd_byte = rd_cnt_hi[inst_sel];
    end else if (reg_sel == `UDT_REG_RCAP_LO) begin
      rd_byte = rd_rcap_lo[inst_sel];
    end else begin
      rd_byte = rd_rcap_hi[inst_sel];
    end
  end

  // apb answer, registered so every bus output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= access;
      pslverr <= access & ~addr_ok;
      if (access) begin
        prdata <= {24'h00_0000, pwrite ? 8'h00 : rd_byte};
      end
    end
  end

  // system clock divided by 12 and by 2, shared by all instances
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_cnt <= 4'h0;
      div2_q <= 1'b0;
    end else begin
      div12_cnt <= (div12_cnt == `UDT_DIV12_LAST) ? 4'h0 : div12_cnt + 4'h1;
      div2_q <= ~div2_q;
    end
  end

  assign tick12 = (div12_cnt == `UDT_DIV12_LAST);
  assign tick2 = div2_q;

  // external oscillator resampled; it must run slower than pclk to be seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_prev <= 1'b0;
      ext_cnt <= 3'h0;
    end else begin
      osc_s1 <= osc_clk_in;
      osc_s2 <= osc_s1;
      osc_prev <= osc_s2;
      if (osc_rise) begin
        ext_cnt <= ext_cnt + 3'h1;
      end
    end
  end

  assign osc_rise = osc_s2 & ~osc_prev;
  assign tick8 = osc_rise & (ext_cnt == `UDT_EXT8_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < `UDT_INST_COUNT; gi = gi + 1) begin : g_tmr
      logic tf;
      logic exf;
      logic exf_irq;
      logic exen;
      logic run;
      logic csel;
      logic cprl;
      logic ie;
      logic dcen;
      udt_clksel_t clksel;
      udt_word_t count;
      udt_word_t rcap;
      logic cnt_s1;
      logic cnt_s2;
      logic cnt_prev;
      logic trg_s1;
      logic trg_s2;
      logic trg_prev;
      logic sel_tick;
      logic tick;
      logic up;
      logic trig_fall;
      logic ext_act;
      logic ovf;
      logic unf;
      logic ev;
      logic wr_here;
      logic wr_ctrl;
      logic wr_cfg;
      logic wr_cnt_lo;
      logic wr_cnt_hi;
      logic wr_rcap_lo;
      logic wr_rcap_hi;
      logic tf_base;
      logic exf_base;

      assign wr_here = apb_wr & addr_ok & (inst_sel == 2'(gi));
      assign wr_ctrl = wr_here & (reg_sel == `UDT_REG_CTRL);
      assign wr_cfg = wr_here & (reg_sel == `UDT_REG_CFG);
      assign wr_cnt_lo = wr_here & (reg_sel == `UDT_REG_CNT_LO);
      assign wr_cnt_hi = wr_here & (reg_sel == `UDT_REG_CNT_HI);
      assign wr_rcap_lo = wr_here & (reg_sel == `UDT_REG_RCAP_LO);
      assign wr_rcap_hi = wr_here & (reg_sel == `UDT_REG_RCAP_HI);

      // two-flop synchronisers plus one history flop for edge detection
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_s1 <= 1'b0;
          cnt_s2 <= 1'b0;
          cnt_prev <= 1'b0;
          trg_s1 <= 1'b0;
          trg_s2 <= 1'b0;
          trg_prev <= 1'b0;
        end else begin
          cnt_s1 <= count_input_pin[gi]; // RULE21
          cnt_s2 <= cnt_s1;
          cnt_prev <= cnt_s2;
          trg_s1 <= trigger_pin[gi]; // RULE21
          trg_s2 <= trg_s1;
          trg_prev <= trg_s2;
        end
      end

      // selected timer clock
      always_comb begin
        case (clksel)
          `UDT_CLK_DIV12: sel_tick = tick12; // RULE18
          `UDT_CLK_SYS: sel_tick = 1'b1; // RULE18
          `UDT_CLK_EXT8: sel_tick = tick8; // RULE18
          default: sel_tick = tick2; // RULE18
        endcase
      end

      // count event from either source, gated by run
      assign tick = run & (csel ? (cnt_prev & ~cnt_s2) : sel_tick); // RULE2 RULE3 RULE14
      assign up = ~dcen | trg_s2; // RULE4
      // trigger acts only with exen set and decrement enable clear
      assign trig_fall = trg_prev & ~trg_s2; // RULE21
      assign ext_act = run & exen & ~dcen & trig_fall; // RULE5 RULE10
      // a trigger reload in reload mode takes the cycle over the tick
      assign ovf = tick & up & (count == `UDT_WORD_MAX) & (cprl | ~ext_act); // RULE8 RULE11
      assign unf = tick & ~up & (cprl ? (count == `UDT_RST_WORD) // RULE9
                                      : ((count == rcap) & ~ext_act)); // RULE13
      assign ev = ovf | unf;

      // control and config fields
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          exen <= 1'b0;
          run <= 1'b0;
          csel <= 1'b0;
          cprl <= 1'b0;
          ie <= 1'b0;
          dcen <= 1'b0;
          clksel <= `UDT_CLK_DIV12;
        end else begin
          if (wr_ctrl) begin
            exen <= wbyte[`UDT_CTRL_EXEN];
            run <= wbyte[`UDT_CTRL_RUN]; // RULE14
            csel <= wbyte[`UDT_CTRL_CSEL];
            cprl <= wbyte[`UDT_CTRL_CPRL]; // RULE10 RULE14
          end
          if (wr_cfg) begin
            ie <= wbyte[`UDT_CFG_IE];
            dcen <= wbyte[`UDT_CFG_DCEN];
            clksel <= {wbyte[`UDT_CFG_CLK_HI], wbyte[`UDT_CFG_CLK_LO]};
          end
        end
      end

      // flags: software write is the base, hardware events win over a clear
      assign tf_base = wr_ctrl ? wbyte[`UDT_CTRL_TF] : tf; // RULE19
      assign exf_base = wr_ctrl ? wbyte[`UDT_CTRL_EXF] : exf; // RULE19

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tf <= 1'b0;
          exf <= 1'b0;
          exf_irq <= 1'b0;
        end else begin
          tf <= tf_base | ev; // RULE8 RULE9 RULE11 RULE13
          if (cprl) begin
            exf <= exf_base | ext_act; // RULE7
            exf_irq <= ext_act | (exf_base & (exf_irq | ~wr_ctrl));
          end else if (ext_act) begin
            exf <= 1'b1; // RULE20
            exf_irq <= 1'b1;
          end else begin
            // toggling acts as a 17th count bit and never interrupts
            exf <= exf_base ^ ev; // RULE15
            exf_irq <= exf_irq & exf_base & ~ev;
          end
        end
      end

      // count: a byte write wins the cycle, the other byte holds
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          count <= `UDT_RST_WORD;
        end else if (wr_cnt_lo) begin
          count[7:0] <= wbyte; // RULE1
        end else if (wr_cnt_hi) begin
          count[15:8] <= wbyte; // RULE1
        end else if (cprl) begin
          if (tick) begin
            count <= up ? count + 16'h0001 : count - 16'h0001; // RULE8 RULE9
          end
        end else if (ext_act) begin
          count <= rcap; // RULE12
        end else if (tick) begin
          if (up) begin
            count <= (count == `UDT_WORD_MAX) ? rcap : count + 16'h0001; // RULE11
          end else begin
            count <= (count == rcap) ? `UDT_WORD_MAX : count - 16'h0001; // RULE13
          end
        end
      end

      // capture/reload pair
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rcap <= `UDT_RST_WORD;
        end else if (wr_rcap_lo) begin
          rcap[7:0] <= wbyte;
        end else if (wr_rcap_hi) begin
          rcap[15:8] <= wbyte;
        end else if (cprl && ext_act) begin
          rcap <= count; // RULE6
        end
      end

      assign rd_ctrl[gi] = {tf, exf, 2'b00, exen, run, csel, cprl};
      assign rd_cfg[gi] = {2'b00, ie, clksel, 2'b00, dcen};
      assign rd_cnt_lo[gi] = count[7:0];
      assign rd_cnt_hi[gi] = count[15:8];
      assign rd_rcap_lo[gi] = rcap[7:0];
      assign rd_rcap_hi[gi] = rcap[15:8];
      assign ev_all[gi] = ev;
      assign irq_all[gi] = ie & (tf | (exf & exf_irq)); // RULE7 RULE8 RULE11
    end
  endgenerate

  // event outputs on the edge of the count update, interrupt outputs one cycle behind it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 3'h0;
      adc_start_trig <= 2'h0;
      dac_update_trig <= 3'h0;
      uart0_baud_tick <= 3'h0;
    end else begin
      timer_irq <= irq_all;
      adc_start_trig <= ev_all[1:0]; // RULE16
      dac_update_trig <= ev_all; // RULE16
      uart0_baud_tick <= ev_all; // RULE17
    end
  end

endmodule

/* test/udt_pins.sv */
// pin-side model: count and trigger pins plus a free-running oscillator
`timescale 1ns/10ps
module udt_pins (
  input wire logic pclk,
  output logic [2:0] count_input_pin,
  output logic [2:0] trigger_pin,
  output logic osc_clk_in
);
  // pins idle high; oscillator runs free at a quarter of pclk
  initial begin
    count_input_pin = 3'h7;
    trigger_pin = 3'h7;
    osc_clk_in = 1'b0;
    forever #100 osc_clk_in = ~osc_clk_in;
  end
  // steady direction level on one trigger pin
  task automatic set_trig(input int i, input logic v);
    trigger_pin[i] <= v;
  endtask
  // n falls, each level held three cycles so the synchroniser sees it
  // limitation: a held-low trigger on that instance is raised again
  task automatic fall(input logic trig, input int i, input int n);
    repeat (n) begin
      @(posedge pclk);
      trigger_pin[i] <= !trig;
      count_input_pin[i] <= trig;
      repeat (3) @(posedge pclk);
      trigger_pin[i] <= 1'b1;
      count_input_pin[i] <= 1'b1;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

/* test/udt_timer_bench.sv */
// self-checking bench for the three-timer block
`timescale 1ns/10ps
`define CHK(got, exp) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      failures++; \
      $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
    end \
  end
module udt_timer_bench
  import udt_pkg::*;
;
  typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] e;} udt_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_clk_in, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] count_input_pin, trigger_pin, timer_irq, dac_update_trig, uart0_baud_tick;
  logic [1:0] adc_start_trig;
  udt_byte_t rd;
  udt_word_t cnt;
  int failures, comparisons;
  int wraps [3];
  int sel_exp [4] = '{40, 484, 15, 242};
  logic [7:0] bad [3] = '{8'h18, 8'h60, 8'h80};
  // write, expected readback; reserved bits read zero
  udt_row_t rows [7] = '{'{8'h10, 8'h5a, 8'h5a}, '{8'h34, 8'ha5, 8'ha5},
    '{8'h48, 8'h3c, 8'h3c}, '{8'h4c, 8'hc3, 8'hc3}, '{8'h24, 8'hff, 8'h39},
    '{8'h00, 8'h3b, 8'h0b}, '{8'h40, 8'h80, 8'h80}};

  udt_timer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .count_input_pin, .trigger_pin, .osc_clk_in,
    .timer_irq, .adc_start_trig, .dac_update_trig, .uart0_baud_tick);
  udt_pins pins (.pclk, .count_input_pin, .trigger_pin, .osc_clk_in);

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // count wrap pulses so scenarios can wait on an event, not a guess
  always @(posedge pclk) begin
    for (int i = 0; i < 3; i++) begin
      if (dac_update_trig[i] === 1'b1) begin
        wraps[i] <= wraps[i] + 1;
      end
    end
  end

  task automatic report_and_stop();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    `CHK({err, rd}, {1'b0, e})
  endtask
  task automatic wait_wrap(input int i);
    int w0;
    w0 = wraps[i];
    for (int n = 0; n < 2000 && wraps[i] == w0; n++) begin
      @(posedge pclk);
    end
    `CHK(wraps[i] != w0, 1'b1)
  endtask

  // whole run is a few thousand cycles; 40000 means a hang
  initial begin
    #2000000;
    failures++;
    report_and_stop();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 3; i++) begin
      for (int r = 0; r < 6; r++) begin
        rdc({1'b0, 2'(i), 3'(r), 2'b00}, 8'h00);
      end
    end
    foreach (rows[k]) begin
      wr(rows[k].a, rows[k].d);
      rdc(rows[k].a, rows[k].e);
    end
    wr(8'h40, 8'h00);
    rdc(8'h40, 8'h00);
    foreach (bad[k]) begin
      apb(1'b0, bad[k], 8'h00);
      `CHK({err, rd}, 9'h100)
      apb(1'b1, bad[k], 8'hff);
      `CHK(err, 1'b1)
    end
    // reset in mid-run must restore zeros
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(8'h00, 8'h00);
    rdc(8'h10, 8'h00);
    // every clock select code, counts measured over a fixed run
    foreach (sel_exp[c]) begin
      wr(8'h08, 8'h00);
      wr(8'h0c, 8'h00);
      wr(8'h04, {3'h0, 2'(c), 3'h0});
      wr(8'h00, 8'h04);
      repeat (480) @(posedge pclk);
      wr(8'h00, 8'h00);
      apb(1'b0, 8'h08, 8'h00);
      cnt[7:0] = rd;
      apb(1'b0, 8'h0c, 8'h00);
      cnt[15:8] = rd;
      `CHK(cnt + 6 >= sel_exp[c] && cnt <= sel_exp[c] + 6, 1'b1)
    end
    // auto-reload up from ffff reloads ff00
    wr(8'h10, 8'h00);
    wr(8'h14, 8'hff);
    wr(8'h08, 8'hfe);
    wr(8'h0c, 8'hff);
    wr(8'h04, 8'h08);
    wr(8'h00, 8'h04);
    wait_wrap(0);
    rdc(8'h00, 8'hc4);
    rdc(8'h0c, 8'hff);
    wr(8'h04, 8'h28);
    repeat (2) @(posedge pclk);
    `CHK(timer_irq[0], 1'b1)
    wr(8'h00, 8'h00);
    repeat (2) @(posedge pclk);
    `CHK(timer_irq[0], 1'b0)
    // down count from 8004 hits reload 8000 and loads ffff
    pins.set_trig(1, 1'b0);
    wr(8'h30, 8'h00);
    wr(8'h34, 8'h80);
    wr(8'h28, 8'h04);
    wr(8'h2c, 8'h80);
    wr(8'h24, 8'h09);
    wr(8'h20, 8'h04);
    wait_wrap(1);
    rdc(8'h2c, 8'hff);
    rdc(8'h20, 8'hc4);
    // capture mode down wraps 0000 to ffff
    wr(8'h20, 8'h00);
    wr(8'h28, 8'h03);
    wr(8'h2c, 8'h00);
    wr(8'h20, 8'h05);
    wait_wrap(1);
    rdc(8'h2c, 8'hff);
    // clear the flags, then turn the direction up so ffff wraps to 0000
    wr(8'h20, 8'h05);
    pins.set_trig(1, 1'b1);
    wait_wrap(1);
    rdc(8'h20, 8'h85);
    wr(8'h20, 8'h00);
    // pin counting, then capture on a trigger fall
    wr(8'h48, 8'h34);
    wr(8'h4c, 8'h12);
    wr(8'h44, 8'h20);
    wr(8'h40, 8'h0f);
    pins.fall(1'b0, 2, 5);
    pins.fall(1'b1, 2, 1);
    rdc(8'h50, 8'h39);
    rdc(8'h54, 8'h12);
    rdc(8'h40, 8'h4f);
    `CHK(timer_irq[2], 1'b1)
    // reload mode: trigger fall reloads 1239 and flags
    wr(8'h40, 8'h0e);
    wr(8'h48, 8'h10);
    wr(8'h4c, 8'h00);
    pins.fall(1'b1, 2, 1);
    rdc(8'h48, 8'h39);
    rdc(8'h40, 8'h4e);
    // decrement enable: trigger fall is direction only
    wr(8'h44, 8'h01);
    wr(8'h40, 8'h0e);
    wr(8'h48, 8'h77);
    pins.fall(1'b1, 2, 1);
    rdc(8'h48, 8'h77);
    rdc(8'h40, 8'h0e);
    // external enable clear: trigger ignored in capture mode
    wr(8'h44, 8'h00);
    wr(8'h40, 8'h07);
    pins.fall(1'b1, 2, 1);
    rdc(8'h40, 8'h07);
    rdc(8'h50, 8'h39);
    report_and_stop();
  end
endmodule

/* test/udt_timer_checker.sv */
// assertion checker bound to the timer block ports
`timescale 1ns/10ps
module udt_timer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] count_input_pin,
  input wire logic [2:0] trigger_pin,
  input wire logic osc_clk_in,
  input wire logic [2:0] timer_irq,
  input wire logic [1:0] adc_start_trig,
  input wire logic [2:0] dac_update_trig,
  input wire logic [2:0] uart0_baud_tick
);
  // single domain, so one clocking and one reset serve every check
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus handshake: one wait state, single-cycle answer
  a_ready_latency: assert property (psel && penable && !pready |=> pready)
    else $error("answer not one cycle after access");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("error without answer");
  a_unmapped_error: assert property (psel && penable && !pready &&
    (paddr[7] || paddr[6:5] == 2'h3) |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_byte_read_width: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // converter and baud outputs are the same wrap events
  a_adc_follows_dac: assert property (adc_start_trig == dac_update_trig[1:0])
    else $error("conversion start differs from wrap");
  a_uart_follows_dac: assert property (uart0_baud_tick == dac_update_trig)
    else $error("baud tick differs from wrap");
  // a request only drops after a software write two cycles before
  a_irq_needs_write: assert property ($fell(timer_irq[0]) |-> $past(pwrite && pready, 2))
    else $error("request dropped without a write");
endmodule

bind udt_timer udt_timer_checker chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .count_input_pin, .trigger_pin, .osc_clk_in, .timer_irq,
  .adc_start_trig, .dac_update_trig, .uart0_baud_tick
);
